// ### tb/dgp_board.sv
module dgp_board (
  input wire logic [7:0] p1_out, // Port one drive value
  input wire logic [7:0] p1_oe, // Port one drive enable
  input wire logic [7:0] drive, // Level the board puts on undriven pins
  output logic [7:0] p1_in // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // A pin the port drives reads back the port's own level
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & drive);
endmodule

// ### tb/tb_dual_gpio_port_with_timer_mux.sv
module tb_dual_gpio_port_with_timer_mux;
  timeunit 1ns;
  timeprecision 1ps;
  import dgp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, tmr_oe;
  logic [7:0] p1_in, p1_out, p1_oe, p4_in, tmr_out, drive, m;
  wire logic hready;
  dgp_pin_func_t pin_func;
  int err_count = 0;
  int checks = 0;
  assign hready = hreadyout;
  dgp_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe),
    .p4_in(p4_in), .tmr_oe(tmr_oe), .tmr_out(tmr_out), .pin_func(pin_func));
  dgp_board board_u (.p1_out(p1_out), .p1_oe(p1_oe), .drive(drive), .p1_in(p1_in));
  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test;
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask
  // Hands back hrdata as sampled at the data-phase edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= DGP_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
    chk("resp", hresp, DGP_HRESP_OKAY);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, {24'h0, d}, x);
  endtask
  // Pins reach pin_func three edges after p1_oe settles; stays on the edge
  task automatic settle;
    repeat (5) @(posedge hclk);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk("oe", p1_oe, 0);
    bus(1'b0, DGP_OFS_DIR, 0, rd);
    chk("dir rd", rd, DGP_DIR_RD_VAL);
    bus(1'b0, DGP_OFS_ODR, 0, rd);
    chk("odr", rd, DGP_ODR_RST);
  endtask
  task automatic t_gpio;
    wr(DGP_OFS_DIR, 8'hf0);
    wr(DGP_OFS_ODR, 8'ha5);
    drive <= 8'h3c;
    settle();
    chk("oe", p1_oe, 8'hf0);
    chk("out", p1_out & p1_oe, 8'ha0);
    bus(1'b0, DGP_OFS_ODR, 0, rd);
    chk("odr", rd, 8'ha5);
    bus(1'b0, DGP_OFS_PIN1, 0, rd);
    chk("pin1", rd, 8'hac);
  endtask
  task automatic t_readonly;
    wr(DGP_OFS_PIN1, 8'h0f);
    wr(DGP_OFS_PIN4, 8'hff);
    wr(12'h010, 8'hff);
    settle();
    chk("oe", p1_oe, 8'hf0);
    bus(1'b0, DGP_OFS_ODR, 0, rd);
    chk("odr", rd, 8'ha5);
    foreach (m[i]) begin
      p4_in <= 8'h5a ^ (8'h1 << i);
      settle();
      bus(1'b0, DGP_OFS_PIN4, 0, rd);
      chk("pin4", rd, 8'h5a ^ (8'h1 << i));
    end
    bus(1'b0, 12'h010, 0, rd);
    chk("unmapped", rd, DGP_RD_ZERO);
  endtask
  task automatic t_timer;
    tmr_oe <= 3'h7;
    tmr_out <= 8'h5a;
    settle();
    chk("tmr over dir oe", p1_oe, 8'hff);
    chk("tmr over dir out", p1_out, 8'h5a);
    wr(DGP_OFS_DIR, 8'h00);
    for (int ch = 0; ch < 3; ch++) begin
      m = (ch == 2) ? 8'hc0 : (ch == 1) ? 8'h30 : 8'h0f;
      tmr_oe <= 3'h1 << ch;
      tmr_out <= 8'h96;
      settle();
      chk("tmr oe", p1_oe, m);
      chk("tmr out", p1_out & m, 8'h96 & m);
    end
    tmr_oe <= 3'h0;
  endtask
  task automatic t_pinfunc;
    for (int k = 0; k < 2; k++) begin
      m = k ? 8'h69 : 8'hb4;
      drive <= m;
      settle();
      chk("cap", pin_func.capture, m);
      chk("clk", pin_func.ext_clock, {m[7], m[5], m[3], m[2]});
      chk("irq", pin_func.ext_irq, {m[6], m[4]});
    end
  endtask
  initial begin
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
    p4_in = 0;
    tmr_oe = 0;
    tmr_out = 0;
    drive = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_gpio();
    t_readonly();
    t_timer();
    t_pinfunc();
    end_of_test();
  end
endmodule

// ### verilog/dgp_pkg.sv
package dgp_pkg;

  // ****************************************************************
  // Register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [11:0] DGP_OFS_DIR = 12'h000;
  localparam logic [11:0] DGP_OFS_ODR = 12'h004;
  localparam logic [11:0] DGP_OFS_PIN1 = 12'h008;
  localparam logic [11:0] DGP_OFS_PIN4 = 12'h00c;
  localparam int DGP_ADDR_W = 12;

  localparam logic [7:0] DGP_DIR_RST = 8'h00;
  localparam logic [7:0] DGP_ODR_RST = 8'h00;
  localparam logic [31:0] DGP_RD_ZERO = 32'h0000_0000;
  // Value returned on reads of the write-only direction register; arbitrary
  localparam logic [31:0] DGP_DIR_RD_VAL = 32'h0000_0000;

  // ****************************************************************
  // Bus encodings
  // ****************************************************************
  localparam logic [1:0] DGP_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DGP_HTRANS_SEQ = 2'h3;
  localparam logic DGP_HRESP_OKAY = 1'b0;

  // ****************************************************************
  // Timer channel ownership of port one pins
  // ****************************************************************
  localparam int DGP_CH2_LO = 6;
  localparam int DGP_CH1_LO = 4;

  // Latched address phase of one bus transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [DGP_ADDR_W-1:0] addr;
  } dgp_aphase_t;

  // Side-channel signals fed from port one pins to the timer and interrupts
  typedef struct packed {
    logic [7:0] capture;
    logic [3:0] ext_clock;
    logic [1:0] ext_irq;
  } dgp_pin_func_t;

endpackage

// ### verilog/dgp_port.sv
// Functional notes
// R1 - Port one has eight pins, each input or output, some shared with timer/interrupts.
// R2 - Direction register is write-only; reads return an undefined, unreliable value.
// R3 - Direction bit 1 makes pin output, 0 input; all reset to 0.
// R4 - Output data register is read/write, drives output pins, resets to 0.
// R5 - Pin-state read returns output data bit where direction bit is 1.
// R6 - Pin-state read returns sampled pin level where direction bit is 0.
// R7 - Port one pin-state register is read-only; writes do nothing.
// R8 - Enabled timer compare output drives pin regardless of direction; channel owns pin group.
// R9 - Input pins feed timer capture, external timer clocks and external interrupts.
// R10 - Second port is eight input-only pins, no direction or output data register.
// R11 - Every read of input-only port returns current pin levels.
// R12 - Input-only port register ignores writes.
// R13 - Pin levels pass a two-flop synchroniser before reaching read data.
module dgp_port import dgp_pkg::*; #(
  parameter int PW = 8
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  input wire logic [PW-1:0] p1_in, // Port one pin levels
  output logic [PW-1:0] p1_out, // Port one pin drive value
  output logic [PW-1:0] p1_oe, // Port one output enable, high drives
  input wire logic [PW-1:0] p4_in, // Input-only port pin levels
  input wire logic [2:0] tmr_oe, // Timer compare output enable per channel
  input wire logic [PW-1:0] tmr_out, // Timer compare output level per pin
  output dgp_pin_func_t pin_func // Capture, clock and interrupt inputs
);

  // ****************************************************************
  // Bus address phase
  // ****************************************************************
  dgp_aphase_t aph_r;
  dgp_aphase_t aph_nxt;
  logic [PW-1:0] dir_r;
  logic [PW-1:0] odr_r;
  logic [PW-1:0] p1_s1_r;
  logic [PW-1:0] p1_s2_r;
  logic [PW-1:0] p4_s1_r;
  logic [PW-1:0] p4_s2_r;
  logic [31:0] rdata_nxt;
  logic [PW-1:0] pin1_view;
  logic [PW-1:0] tmr_own;
  logic [PW-1:0] p1_out_nxt;
  logic [PW-1:0] p1_oe_nxt;
  dgp_pin_func_t func_nxt;

  wire take = hsel && hready && (htrans == DGP_HTRANS_NONSEQ || htrans == DGP_HTRANS_SEQ);
  wire [DGP_ADDR_W-1:0] aaddr = haddr[DGP_ADDR_W-1:0];
  wire rd_take = take && !hwrite;
  wire wr_dir = aph_r.valid && aph_r.write && aph_r.addr == DGP_OFS_DIR;
  wire wr_odr = aph_r.valid && aph_r.write && aph_r.addr == DGP_OFS_ODR;

  always_comb begin
    aph_nxt.valid = take;
    aph_nxt.write = hwrite;
    aph_nxt.addr = aaddr;
  end

  // ****************************************************************
  // Pin mux and timer ownership
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < PW; g++) begin : g_pin
      if (g >= DGP_CH2_LO) begin : g_c2
        assign tmr_own[g] = tmr_oe[2]; // [R8]
      end else if (g >= DGP_CH1_LO) begin : g_c1
        assign tmr_own[g] = tmr_oe[1]; // [R8]
      end else begin : g_c0
        assign tmr_own[g] = tmr_oe[0]; // [R8]
      end
      // Timer output wins over the direction bit
      assign p1_oe_nxt[g] = tmr_own[g] | dir_r[g]; // [R1] [R3] [R8]
      assign p1_out_nxt[g] = tmr_own[g] ? tmr_out[g] : odr_r[g]; // [R4] [R8]
      assign pin1_view[g] = dir_r[g] ? odr_r[g] : p1_s2_r[g]; // [R5] [R6]
      // Capture sees the pin only when nothing drives it; else held low
      assign func_nxt.capture[g] = !tmr_own[g] && !dir_r[g] && p1_s2_r[g]; // [R9]
    end
  endgenerate

  assign func_nxt.ext_clock = {func_nxt.capture[7], func_nxt.capture[5],
                               func_nxt.capture[3], func_nxt.capture[2]}; // [R9]
  assign func_nxt.ext_irq = {func_nxt.capture[6], func_nxt.capture[4]}; // [R9]

  // ****************************************************************
  // Read data select, word returned in the data phase
  // ****************************************************************
  always_comb begin
    rdata_nxt = DGP_RD_ZERO;
    case (aaddr)
      DGP_OFS_DIR: rdata_nxt = DGP_DIR_RD_VAL; // [R2]
      DGP_OFS_ODR: rdata_nxt[PW-1:0] = odr_r; // [R4]
      DGP_OFS_PIN1: rdata_nxt[PW-1:0] = pin1_view; // [R5] [R6]
      DGP_OFS_PIN4: rdata_nxt[PW-1:0] = p4_s2_r; // [R10] [R11]
      default: rdata_nxt = DGP_RD_ZERO;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_r <= '0;
      hrdata <= DGP_RD_ZERO;
    end else begin
      aph_r <= aph_nxt;
      // Sampling at the address phase keeps the answer zero-wait
      if (rd_take) begin
        hrdata <= rdata_nxt;
      end
    end
  end

  // Writes to either pin-state register decode to nothing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_r <= DGP_DIR_RST; // [R3]
      odr_r <= DGP_ODR_RST; // [R4]
    end else begin
      if (wr_dir) begin
        dir_r <= hwdata[PW-1:0]; // [R3]
      end
      if (wr_odr) begin
        odr_r <= hwdata[PW-1:0]; // [R4] [R7] [R12]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p1_s1_r <= '0;
      p1_s2_r <= '0;
      p4_s1_r <= '0;
      p4_s2_r <= '0;
    end else begin
      p1_s1_r <= p1_in; // [R13]
      p1_s2_r <= p1_s1_r; // [R13]
      p4_s1_r <= p4_in; // [R13]
      p4_s2_r <= p4_s1_r; // [R13]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p1_out <= '0;
      p1_oe <= '0;
      pin_func <= '0;
    end else begin
      p1_out <= p1_out_nxt;
      p1_oe <= p1_oe_nxt;
      pin_func <= func_nxt;
    end
  end

  // Never stalls, never errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= DGP_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= DGP_HRESP_OKAY;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_odr_write;
    aph_r.valid && aph_r.write && aph_r.addr == DGP_OFS_ODR;
  endsequence

  sequence s_pin1_read;
    rd_take && aaddr == DGP_OFS_PIN1;
  endsequence

  sequence s_pin4_read;
    rd_take && aaddr == DGP_OFS_PIN4;
  endsequence

  sequence s_odr_read;
    rd_take && aaddr == DGP_OFS_ODR;
  endsequence

  sequence s_readonly_write;
    aph_r.valid && aph_r.write && (aph_r.addr == DGP_OFS_PIN1 || aph_r.addr == DGP_OFS_PIN4);
  endsequence

  // Reset values, checked at the first edge after release
  a_dir_reset_zero: assert property (@(posedge hclk) $rose(hresetn) |-> dir_r == '0) // [R3]
    else $error("direction not zero after reset");
  a_odr_reset_zero: assert property (@(posedge hclk) $rose(hresetn) |-> odr_r == '0) // [R4]
    else $error("output data not zero after reset");
  a_oe_reset_zero: assert property (@(posedge hclk) $rose(hresetn) |-> p1_oe == '0) // [R3]
    else $error("pins driven after reset");

  // ****************************************************************
  // Register writes and reads
  // ****************************************************************
  a_odr_write_lands: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
    s_odr_write |=> odr_r == $past(hwdata[PW-1:0]))
    else $error("output data write lost");
  a_dir_write_lands: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    wr_dir |=> dir_r == $past(hwdata[PW-1:0]))
    else $error("direction write lost");
  a_dir_holds_idle: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    !wr_dir |=> $stable(dir_r))
    else $error("direction changed without a write");
  a_odr_holds_idle: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
    !wr_odr |=> $stable(odr_r))
    else $error("output data changed without a write");
  a_odr_read_back: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
    s_odr_read |=> hrdata[PW-1:0] == $past(odr_r) && hrdata[31:PW] == '0)
    else $error("output data read wrong");
  a_dir_read_fixed: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
    rd_take && aaddr == DGP_OFS_DIR |=> hrdata == DGP_DIR_RD_VAL)
    else $error("direction read value changed");
  a_pin_state_no_write: assert property (@(posedge hclk) disable iff (!hresetn) // [R7] [R12]
    s_readonly_write |=> $stable(dir_r) && $stable(odr_r))
    else $error("write to read-only register had effect");

  // ****************************************************************
  // Pin-state reads
  // ****************************************************************
  a_pin1_read_view: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
    s_pin1_read |=> (hrdata[PW-1:0] & $past(dir_r)) == ($past(odr_r) & $past(dir_r)))
    else $error("pin-state read wrong");
  a_pin1_input_bits: assert property (@(posedge hclk) disable iff (!hresetn) // [R6] [R13]
    s_pin1_read |=> (hrdata[PW-1:0] & ~$past(dir_r)) == ($past(p1_in, 3) & ~$past(dir_r))
    or $past(p1_in, 3) != $past(p1_in, 2))
    else $error("input bits not pin level");
  a_pin1_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
    s_pin1_read |=> hrdata[31:PW] == '0)
    else $error("pin-state read upper bits set");
  a_pin4_read_level: assert property (@(posedge hclk) disable iff (!hresetn) // [R11] [R13]
    rd_take && aaddr == DGP_OFS_PIN4 && $stable(p4_in) && $past($stable(p4_in))
    |=> hrdata[PW-1:0] == $past(p4_in))
    else $error("input port read not pin level");
  a_pin4_read_sync: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
    s_pin4_read |=> hrdata[PW-1:0] == $past(p4_s2_r) && hrdata[31:PW] == '0)
    else $error("input port read not synced level");
  // Depth checks wait two edges after reset, until both flops have loaded pin levels
  a_pin1_sync_depth: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    $past(hresetn, 2) |-> p1_s2_r == $past(p1_in, 2))
    else $error("port one synchroniser depth wrong");
  a_pin4_sync_depth: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    $past(hresetn, 2) |-> p4_s2_r == $past(p4_in, 2))
    else $error("input port synchroniser depth wrong");

  // ****************************************************************
  // Pin drive and timer ownership
  // ****************************************************************
  a_dir_drives_pin: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    dir_r != '0 |=> (p1_oe & $past(dir_r)) == $past(dir_r))
    else $error("output pin not driven");
  a_idle_pins_float: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    dir_r == '0 && tmr_oe == '0 |=> p1_oe == '0)
    else $error("input pin driven");
  a_odr_on_pins: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
    tmr_oe == '0 |=> p1_out == $past(odr_r))
    else $error("output data not on pins");
  a_timer_owns_pin: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
    tmr_oe[0] |=> p1_oe[0] && p1_out[0] == $past(tmr_out[0]))
    else $error("timer output not on pin");
  a_timer_ch0_pins: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
    tmr_oe[0] |=> p1_oe[DGP_CH1_LO-1:0] == '1
      && p1_out[DGP_CH1_LO-1:0] == $past(tmr_out[DGP_CH1_LO-1:0]))
    else $error("channel zero output not on its pins");
  a_timer_ch1_pins: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
    tmr_oe[1] |=> p1_oe[DGP_CH2_LO-1:DGP_CH1_LO] == '1
      && p1_out[DGP_CH2_LO-1:DGP_CH1_LO] == $past(tmr_out[DGP_CH2_LO-1:DGP_CH1_LO]))
    else $error("channel one output not on its pins");
  a_timer_ch2_pins: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
    tmr_oe[2] |=> p1_oe[PW-1:DGP_CH2_LO] == '1
      && p1_out[PW-1:DGP_CH2_LO] == $past(tmr_out[PW-1:DGP_CH2_LO]))
    else $error("channel two output not on its pins");

  // ****************************************************************
  // Capture, clock and interrupt feeds
  // ****************************************************************
  a_capture_gated: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    (tmr_own[4] || dir_r[4]) |=> !pin_func.ext_irq[0])
    else $error("interrupt fed while pin driven");
  a_capture_follows_pin: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    dir_r == '0 && tmr_oe == '0 |=> pin_func.capture == $past(p1_s2_r))
    else $error("capture not pin level");
  a_capture_dir_gated: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    dir_r != '0 |=> (pin_func.capture & $past(dir_r)) == '0)
    else $error("capture fed from output pin");
  a_capture_timer_gated: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    tmr_oe[2] |=> pin_func.capture[PW-1:DGP_CH2_LO] == '0)
    else $error("capture fed from timer-driven pin");
  a_ext_clock_map: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    dir_r == '0 && tmr_oe == '0
    |=> pin_func.ext_clock == {$past(p1_s2_r[7]), $past(p1_s2_r[5]), $past(p1_s2_r[3]), $past(p1_s2_r[2])})
    else $error("external clock feed wrong");
  a_ext_irq_map: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    dir_r == '0 && tmr_oe == '0
    |=> pin_func.ext_irq == {$past(p1_s2_r[6]), $past(p1_s2_r[4])})
    else $error("external interrupt feed wrong");

endmodule
